// >>> logic/crf_core.sv
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module crf_core
  import crf_pkg::*;
#(
  parameter int          IRQ_N       = 4,
  parameter logic [15:0] IRQ_VEC_TOP = 16'hFFFC,
  parameter logic [7:0]  OPC_RSP     = 8'h9C,
  parameter logic [7:0]  OPC_CLI     = 8'h9A,
  parameter logic [7:0]  OPC_RTI     = 8'h80,
  parameter logic [7:0]  OPC_PUSH_INDEX_HIGH    = 8'h8B,
  parameter logic [7:0]  OPC_PULL_INDEX_HIGH    = 8'h8A,
  parameter logic [7:0]  OPC_DAA     = 8'h72,
  parameter logic [7:0]  OPC_ASLA    = 8'h48,
  parameter logic [7:0]  OPC_ASRA    = 8'h47
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // Memory bus
  output crf_mem_req_s          mem_req_o,
  input  wire logic [7:0]       mem_rdata_i,
  // Interrupt requests, bit 0 highest priority
  input  wire logic [IRQ_N-1:0] irq_i,
  // Register port
  input  wire logic [3:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic [7:0]            reg_rdata_o
);

  if (IRQ_N < 1 || IRQ_N > 8) begin : g_chk
    $error("IRQ_N must be 1 to 8");
  end

  // ==========================================================
  // State
  crf_state_e   st_q, st_d;
  logic [7:0]   a_q, a_d, x_q, x_d, h_q, h_d;
  logic [7:0]   op_q, op_d, offh_q, offh_d;
  logic [15:0]  sp_q, sp_d, pc_q, pc_d, vec_q, vec_d;
  crf_ccr_s     cc_q, cc_d;
  logic [2:0]   cnt_q, cnt_d;
  logic         pull_all_q, pull_all_d;
  logic         run_q;
  crf_mem_req_s mem_d;

  // ==========================================================
  // Decode wires
  wire [15:0] hx      = {h_q, x_q};
  wire [7:0]  opc     = (st_q == ST_DECODE) ? mem_rdata_i : op_q;
  wire [15:0] rel16   = {{8{mem_rdata_i[7]}}, mem_rdata_i};
  wire [15:0] pc_inc  = pc_q + 16'h0001;
  wire [15:0] sp_inc  = sp_q + 16'h0001;
  wire [15:0] sp_dec  = sp_q - 16'h0001;
  wire        halted  = (st_q == ST_HALT);
  wire [7:0]  cc_rd   = cc_q | CCR_ONES;

  function automatic logic alu_sel(input logic [3:0] nib);
    alu_sel = (nib == ALU_AND) || (nib == ALU_ADC) || (nib == ALU_ADD);
  endfunction

  function automatic logic is_branch(input logic [7:0] op);
    is_branch = (op == OPC_BCC) || (op == OPC_BCS) || (op == OPC_BGE) ||
                (op == OPC_BLT) || (op == OPC_BGT) || (op == OPC_BLE);
  endfunction

  // Signed forms look at N xor V rather than N alone
  function automatic logic br_taken(input logic [7:0] op,
                                    input crf_ccr_s cc);
    logic nv;
    nv = cc.n ^ cc.v;
    case (op)
      OPC_BCC: br_taken = ~cc.c;
      OPC_BCS: br_taken = cc.c;
      OPC_BGE: br_taken = ~nv;
      OPC_BLT: br_taken = nv;
      OPC_BGT: br_taken = ~(cc.z | nv);
      OPC_BLE: br_taken = cc.z | nv;
      default: br_taken = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Arithmetic on accumulator and incoming operand
  wire       cin   = (op_q[3:0] == ALU_ADC) & cc_q.c;
  wire [8:0] sum9  = {1'b0, a_q} + {1'b0, mem_rdata_i} + {8'h00, cin};
  wire [4:0] sum5  = {1'b0, a_q[3:0]} + {1'b0, mem_rdata_i[3:0]}
                   + {4'h0, cin};
  wire       add_v = (a_q[7] == mem_rdata_i[7]) & (sum9[7] != a_q[7]);
  wire [7:0] and_r = a_q & mem_rdata_i;
  wire       daa_hi = cc_q.c | (a_q > DAA_LIMIT);
  wire       daa_lo = cc_q.h | (a_q[3:0] > DIGIT_MAX);
  wire [7:0] daa_r  = a_q + (daa_hi ? DAA_HI_CORR : 8'h00)
                    + (daa_lo ? DAA_LO_CORR : 8'h00);
  wire [7:0] asl_r  = {a_q[6:0], 1'b0};
  wire [7:0] asr_r  = {a_q[7], a_q[7:1]};

  // ==========================================================
  // Interrupt selection
  function automatic logic [2:0] irq_pick(input logic [IRQ_N-1:0] req);
    irq_pick = 3'h0;
    for (int k = IRQ_N - 1; k >= 0; k--) begin
      if (req[k]) begin
        irq_pick = 3'(k);
      end
    end
  endfunction

  wire        irq_any = |irq_i;
  wire        int_go  = irq_any & ~cc_q.i;
  wire [2:0]  irq_idx = irq_pick(irq_i);
  wire [15:0] irq_vec = IRQ_VEC_TOP - {12'h000, irq_idx, 1'b0};
  wire [2:0]  pull_n  = pull_all_q ? RTI_PULL_N : PULL_INDEX_HIGH_PULL_N;

  // Byte stacked at each step of interrupt entry; H is left out
  logic [7:0] push_b;
  always_comb begin
    case (cnt_q)
      3'h0:    push_b = pc_q[7:0];
      3'h1:    push_b = pc_q[15:8];
      3'h2:    push_b = x_q;
      3'h3:    push_b = a_q;
      default: push_b = cc_rd;
    endcase
  end

  // ==========================================================
  // Register port read decode
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      REG_A:    rd_mux = a_q;
      REG_X:    rd_mux = x_q;
      REG_H:    rd_mux = h_q;
      REG_SPH:  rd_mux = sp_q[15:8];
      REG_SPL:  rd_mux = sp_q[7:0];
      REG_PCH:  rd_mux = pc_q[15:8];
      REG_PCL:  rd_mux = pc_q[7:0];
      REG_CCR:  rd_mux = cc_rd;
      REG_CTRL: rd_mux = {7'h00, run_q};
      REG_STAT: rd_mux = {6'h00, irq_any, halted};
      default:  rd_mux = 8'h00;
    endcase
  end

  // ==========================================================
  // Sequencer
  always_comb begin
    st_d       = st_q;
    a_d        = a_q;
    x_d        = x_q;
    h_d        = h_q;
    op_d       = op_q;
    offh_d     = offh_q;
    sp_d       = sp_q;
    pc_d       = pc_q;
    vec_d      = vec_q;
    cc_d       = cc_q;
    cnt_d      = cnt_q;
    pull_all_d = pull_all_q;
    mem_d      = '0;
    case (st_q)
      ST_VEC_HI: begin
        mem_d.addr = vec_q;
        mem_d.rd   = 1'b1;
        st_d       = ST_VEC_LO;
      end
      ST_VEC_LO: begin
        pc_d[15:8] = mem_rdata_i;
        mem_d.addr = vec_q + 16'h0001;
        mem_d.rd   = 1'b1;
        st_d       = ST_VEC_END;
      end
      ST_VEC_END: begin
        pc_d[7:0] = mem_rdata_i;
        st_d      = ST_FETCH;
      end
      ST_HALT: begin
        if (run_q) begin
          st_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!run_q) begin
          st_d = ST_HALT;
        end else if (int_go) begin
          cnt_d = 3'h0;
          st_d  = ST_INT;
        end else begin
          mem_d.addr = pc_q;
          mem_d.rd   = 1'b1;
          pc_d       = pc_inc;
          st_d       = ST_DECODE;
        end
      end
      ST_DECODE: begin
        op_d = mem_rdata_i;
        st_d = ST_FETCH;
        if (opc == OPC_PFX || opc == OPC_AIS || opc == OPC_AIX ||
            is_branch(opc) ||
            (opc[7:4] == MODE_IMM && alu_sel(opc[3:0]))) begin
          mem_d.addr = pc_q;
          mem_d.rd   = 1'b1;
          pc_d       = pc_inc;
          st_d       = (opc == OPC_PFX) ? ST_PREFIX : ST_EXEC;
        end else if (opc[7:4] == MODE_IX && alu_sel(opc[3:0])) begin
          mem_d.addr = hx;
          mem_d.rd   = 1'b1;
          st_d       = ST_EXEC;
        end else if (opc == OPC_RSP) begin
          sp_d[7:0] = SP_LOW_RESET;
        end else if (opc == OPC_CLI) begin
          cc_d.i = 1'b0;
        end else if (opc == OPC_DAA) begin
          a_d    = daa_r;
          cc_d.c = cc_q.c | daa_hi;
          cc_d.n = daa_r[7];
          cc_d.z = (daa_r == 8'h00);
        end else if (opc == OPC_ASLA || opc == OPC_ASRA) begin
          a_d    = (opc == OPC_ASLA) ? asl_r : asr_r;
          cc_d.c = (opc == OPC_ASLA) ? a_q[7] : a_q[0];
          cc_d.n = a_d[7];
          cc_d.z = (a_d == 8'h00);
          cc_d.v = a_d[7] ^ cc_d.c;
        end else if (opc == OPC_PUSH_INDEX_HIGH) begin
          mem_d.addr  = sp_q;
          mem_d.wdata = h_q;
          mem_d.wr    = 1'b1;
          sp_d        = sp_dec;
        end else if (opc == OPC_PULL_INDEX_HIGH || opc == OPC_RTI) begin
          cnt_d      = 3'h0;
          pull_all_d = (opc == OPC_RTI);
          st_d       = ST_PULL;
        end
      end
      ST_PREFIX: begin
        op_d = mem_rdata_i;
        st_d = ST_FETCH;
        if (alu_sel(mem_rdata_i[3:0]) && (mem_rdata_i[7:4] == MODE_SP1 ||
            mem_rdata_i[7:4] == MODE_SP2)) begin
          mem_d.addr = pc_q;
          mem_d.rd   = 1'b1;
          pc_d       = pc_inc;
          st_d = (mem_rdata_i[7:4] == MODE_SP1) ? ST_SPOFF1 : ST_SPOFF2;
        end
      end
      ST_SPOFF1: begin
        mem_d.addr = sp_q + {8'h00, mem_rdata_i};
        mem_d.rd   = 1'b1;
        st_d       = ST_EXEC;
      end
      ST_SPOFF2: begin
        offh_d     = mem_rdata_i;
        mem_d.addr = pc_q;
        mem_d.rd   = 1'b1;
        pc_d       = pc_inc;
        st_d       = ST_SPOFF2L;
      end
      ST_SPOFF2L: begin
        mem_d.addr = sp_q + {offh_q, mem_rdata_i};
        mem_d.rd   = 1'b1;
        st_d       = ST_EXEC;
      end
      ST_EXEC: begin
        if (is_branch(op_q)) begin
          if (br_taken(op_q, cc_q)) begin
            pc_d = pc_q + rel16;
          end
          st_d = ST_FETCH;
        end else begin
          if (op_q == OPC_AIS) begin
            sp_d = sp_q + rel16;
          end else if (op_q == OPC_AIX) begin
            {h_d, x_d} = hx + rel16;
          end else if (op_q[3:0] == ALU_AND) begin
            a_d    = and_r;
            cc_d.v = 1'b0;
            cc_d.n = and_r[7];
            cc_d.z = (and_r == 8'h00);
          end else begin
            a_d    = sum9[7:0];
            cc_d.v = add_v;
            cc_d.h = sum5[4];
            cc_d.n = sum9[7];
            cc_d.z = (sum9[7:0] == 8'h00);
            cc_d.c = sum9[8];
          end
          // Overlap the next opcode fetch to keep two-cycle ops
          st_d = ST_FETCH;
          if (run_q && !int_go) begin
            mem_d.addr = pc_q;
            mem_d.rd   = 1'b1;
            pc_d       = pc_inc;
            st_d       = ST_DECODE;
          end
        end
      end
      ST_INT: begin
        mem_d.addr  = sp_q;
        mem_d.wdata = push_b;
        mem_d.wr    = 1'b1;
        sp_d        = sp_dec;
        cnt_d       = cnt_q + 3'h1;
        if (cnt_q == INT_PUSH_LAST) begin
          cc_d.i = 1'b1;
          vec_d  = irq_vec;
          st_d   = ST_VEC_HI;
        end
      end
      ST_PULL: begin
        if (cnt_q != 3'h0) begin
          if (!pull_all_q) begin
            h_d = mem_rdata_i;
          end else begin
            case (cnt_q)
              3'h1:    cc_d = crf_ccr_s'(mem_rdata_i | CCR_ONES);
              3'h2:    a_d = mem_rdata_i;
              3'h3:    x_d = mem_rdata_i;
              3'h4:    pc_d[15:8] = mem_rdata_i;
              default: pc_d[7:0] = mem_rdata_i;
            endcase
          end
        end
        if (cnt_q == pull_n) begin
          st_d = ST_FETCH;
        end else begin
          mem_d.addr = sp_inc;
          mem_d.rd   = 1'b1;
          sp_d       = sp_inc;
          cnt_d      = cnt_q + 3'h1;
        end
      end
      default: st_d = ST_FETCH;
    endcase
    // Software may load core registers only while the core is halted
    if (halted && reg_wr_i) begin
      case (reg_addr_i)
        REG_A:   a_d = reg_wdata_i;
        REG_X:   x_d = reg_wdata_i;
        REG_H:   h_d = reg_wdata_i;
        REG_SPH: sp_d[15:8] = reg_wdata_i;
        REG_SPL: sp_d[7:0] = reg_wdata_i;
        REG_PCH: pc_d[15:8] = reg_wdata_i;
        REG_PCL: pc_d[7:0] = reg_wdata_i;
        REG_CCR: cc_d = crf_ccr_s'({reg_wdata_i[7:4], cc_q.i,
                                    reg_wdata_i[2:0]} | CCR_ONES);
        default: ;
      endcase
    end
  end

  assign mem_req_o = mem_d;

  // ==========================================================
  // Flip-flops
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q       <= ST_VEC_HI;
      vec_q      <= RESET_VEC;
      sp_q       <= SP_RESET;
      cc_q       <= crf_ccr_s'(CCR_RESET);
      pc_q       <= 16'h0000;
      a_q        <= 8'h00;
      x_q        <= 8'h00;
      h_q        <= 8'h00;
      op_q       <= 8'h00;
      offh_q     <= 8'h00;
      cnt_q      <= 3'h0;
      pull_all_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      vec_q      <= vec_d;
      sp_q       <= sp_d;
      cc_q       <= cc_d;
      pc_q       <= pc_d;
      a_q        <= a_d;
      x_q        <= x_d;
      h_q        <= h_d;
      op_q       <= op_d;
      offh_q     <= offh_d;
      cnt_q      <= cnt_d;
      pull_all_q <= pull_all_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q       <= RUN_RESET;
      reg_rdata_o <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        run_q <= reg_wdata_i[0];
      end
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
    end
  end

endmodule
`default_nettype wire

// >>> shared/crf_pkg.sv
package crf_pkg;

  // ==========================================================
  // Reset values and vectors
  localparam logic [15:0] SP_RESET     = 16'h00FF;
  localparam logic [7:0]  SP_LOW_RESET = 8'hFF;
  localparam logic [15:0] RESET_VEC    = 16'hFFFE;
  localparam logic [7:0]  CCR_RESET    = 8'h68;
  localparam logic [7:0]  CCR_ONES     = 8'h60;

  // ==========================================================
  // Documented opcodes, modes and ALU selectors
  localparam logic [7:0] OPC_AIS = 8'hA7;
  localparam logic [7:0] OPC_AIX = 8'hAF;
  localparam logic [7:0] OPC_BCC = 8'h24;
  localparam logic [7:0] OPC_BCS = 8'h25;
  localparam logic [7:0] OPC_BGE = 8'h90;
  localparam logic [7:0] OPC_BLT = 8'h91;
  localparam logic [7:0] OPC_BGT = 8'h92;
  localparam logic [7:0] OPC_BLE = 8'h93;
  localparam logic [7:0] OPC_PFX = 8'h9E;
  localparam logic [3:0] MODE_IMM = 4'hA;
  localparam logic [3:0] MODE_IX  = 4'hF;
  localparam logic [3:0] MODE_SP1 = 4'hE;
  localparam logic [3:0] MODE_SP2 = 4'hD;
  localparam logic [3:0] ALU_AND  = 4'h4;
  localparam logic [3:0] ALU_ADC  = 4'h9;
  localparam logic [3:0] ALU_ADD  = 4'hB;

  // ==========================================================
  // Decimal adjust figures
  localparam logic [7:0] DAA_LIMIT   = 8'h99;
  localparam logic [3:0] DIGIT_MAX   = 4'h9;
  localparam logic [7:0] DAA_HI_CORR = 8'h60;
  localparam logic [7:0] DAA_LO_CORR = 8'h06;

  // ==========================================================
  // Stacking
  localparam logic [2:0] INT_PUSH_LAST = 3'h4;
  localparam logic [2:0] RTI_PULL_N    = 3'h5;
  localparam logic [2:0] PULL_INDEX_HIGH_PULL_N   = 3'h1;

  // ==========================================================
  // Register port map
  localparam logic [3:0] REG_A     = 4'h0;
  localparam logic [3:0] REG_X     = 4'h1;
  localparam logic [3:0] REG_H     = 4'h2;
  localparam logic [3:0] REG_SPH   = 4'h3;
  localparam logic [3:0] REG_SPL   = 4'h4;
  localparam logic [3:0] REG_PCH   = 4'h5;
  localparam logic [3:0] REG_PCL   = 4'h6;
  localparam logic [3:0] REG_CCR   = 4'h7;
  localparam logic [3:0] REG_CTRL  = 4'h8;
  localparam logic [3:0] REG_STAT  = 4'h9;
  localparam logic       RUN_RESET = 1'b1;

  typedef struct packed {
    logic v;
    logic one6;
    logic one5;
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } crf_ccr_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } crf_mem_req_s;

  typedef enum logic [3:0] {
    ST_VEC_HI, ST_VEC_LO, ST_VEC_END, ST_FETCH, ST_HALT, ST_DECODE,
    ST_PREFIX, ST_SPOFF1, ST_SPOFF2, ST_SPOFF2L, ST_EXEC, ST_INT,
    ST_PULL
  } crf_state_e;

endpackage

// >>> tb/crf_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module crf_core_checker
  import crf_pkg::*;
#(
  parameter int          IRQ_N       = 4,
  parameter logic [15:0] IRQ_VEC_TOP = 16'hFFFC
) (
  // Clock and reset
  input wire logic             core_clk_i,
  input wire logic             rst_n_i,
  // Memory bus
  input wire crf_mem_req_s     mem_req_o,
  input wire logic [7:0]       mem_rdata_i,
  // Interrupt requests
  input wire logic [IRQ_N-1:0] irq_i,
  // Register port
  input wire logic [3:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_rdata_o
);
  wire logic        mem_rd   = mem_req_o.rd;
  wire logic        mem_wr   = mem_req_o.wr;
  wire logic [15:0] mem_addr = mem_req_o.addr;
  wire logic [15:0] rel_sx   = {{8{mem_rdata_i[7]}}, mem_rdata_i};

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Mirror of the run bit: a halted core skips the opcode fetch
  logic run_seen_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_seen_q <= RUN_RESET;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      run_seen_q <= reg_wdata_i[0];
    end
  end

  // ==========================================================
  // Sequences
  sequence push5;
    mem_wr [*5] ##1 !mem_wr;
  endsequence
  sequence imm_seen;
    mem_rd ##1 (mem_rdata_i == OPC_AIS || mem_rdata_i == OPC_AIX);
  endsequence
  // Target check holds only for a taken branch; stimulus keeps carry clear
  // and raises requests only while halted, so the fetch runs unless stopped
  sequence bcc_seen;
    mem_rd ##1 (mem_rdata_i == OPC_BCC);
  endsequence

  // ==========================================================
  // Properties
  chk_reset_vector: assert property (
    $rose(rst_n_i) |-> ##[0:1] (mem_rd && mem_addr == RESET_VEC)
      ##1 (mem_rd && mem_addr == 16'hFFFF))
    else $error("reset vector fetch out of order");
  chk_reg_idle: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("register read data not idle");
  chk_ccr_ones: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) == REG_CCR
      |-> reg_rdata_o[6:5] == 2'b11)
    else $error("condition code bits 6 and 5 not one");
  chk_push_descend: assert property (
    mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("stack push did not descend");
  chk_int_entry: assert property (
    $rose(mem_wr) |-> push5 ##0
      (mem_rd && mem_addr[15:4] == IRQ_VEC_TOP[15:4]))
    else $error("interrupt entry not five pushes then vector");
  chk_int_priority: assert property (
    $rose(mem_wr) && irq_i[0] |-> ##5 (mem_rd && mem_addr == IRQ_VEC_TOP))
    else $error("highest priority vector not fetched");
  chk_imm_timing: assert property (
    imm_seen |-> (mem_rd && mem_addr == $past(mem_addr) + 16'h0001)
      ##1 (mem_rd && mem_addr == $past(mem_addr) + 16'h0001))
    else $error("add immediate not two cycles");
  chk_bcc_target: assert property (
    bcc_seen ##2 run_seen_q |->
      (mem_rd && mem_addr == $past(mem_addr, 3) + 16'h0002 + $past(rel_sx)))
    else $error("carry clear branch target or timing wrong");
endmodule

bind crf_core crf_core_checker #(
  .IRQ_N       (IRQ_N),
  .IRQ_VEC_TOP (IRQ_VEC_TOP)
) u_chk (
  .core_clk_i  (core_clk_i),
  .rst_n_i     (rst_n_i),
  .mem_req_o   (mem_req_o),
  .mem_rdata_i (mem_rdata_i),
  .irq_i       (irq_i),
  .reg_addr_i  (reg_addr_i),
  .reg_wdata_i (reg_wdata_i),
  .reg_wr_i    (reg_wr_i),
  .reg_rd_i    (reg_rd_i),
  .reg_rdata_o (reg_rdata_o)
);
`default_nettype wire

// >>> tb/crf_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module crf_core_tb;
  import crf_pkg::*;

  typedef struct packed {
    logic [3:0] a;
    logic [7:0] v;
  } crf_row_s;

  logic         core_clk  = 1'b0;
  logic         rst_n     = 1'b0;
  crf_mem_req_s mem_req;
  logic [7:0]   mem_rdata;
  logic [3:0]   irq       = 4'h0;
  logic [3:0]   reg_addr  = 4'h0;
  logic [7:0]   reg_wdata = 8'h00;
  logic         reg_wr    = 1'b0;
  logic         reg_rd    = 1'b0;
  logic [7:0]   reg_rdata;
  int           mismatches  = 0;
  int           comparisons = 0;

  // ADD_IMM_TO_STACK_PTR, ADD_IMM_TO_INDEX, BCC, RSP, ADD, ADD, AND, ADC, CLEAR_INTERRUPT_MASK_INSTR, then a BCC loop
  logic [7:0] prog [0:19] = '{8'hA7, 8'h10, 8'hAF, 8'hFE, 8'h24, 8'h02,
    8'h9D, 8'h9D, 8'h9C, 8'hAB, 8'h80, 8'hAB, 8'h88, 8'hA4, 8'hF7,
    8'hA9, 8'h7F, 8'h9A, 8'h24, 8'hFE};
  // Stack-offset ADD, DAA, ADD, ADD, BRANCH_SIGNED_LESS over an ADD, then a BCC loop
  logic [7:0] prog2 [0:13] = '{8'h9E, 8'hEB, 8'h02, 8'h72, 8'hAB, 8'h70,
    8'hAB, 8'h70, 8'h91, 8'h02, 8'hAB, 8'h01, 8'h24, 8'hFE};
  crf_row_s rows [0:9] = '{
    '{REG_SPH, 8'h01},
    '{REG_SPL, 8'hFF},
    '{REG_H, 8'hFF},
    '{REG_X, 8'hFE},
    '{REG_A, 8'h80},
    '{REG_CCR, 8'hF4},
    '{REG_PCH, 8'h10},
    '{REG_CTRL, 8'h00},
    '{REG_STAT, 8'h01},
    '{4'hF, 8'h00}};

  always #20 core_clk = ~core_clk;

  crf_core dut (
    .core_clk_i  (core_clk),
    .rst_n_i     (rst_n),
    .mem_req_o   (mem_req),
    .mem_rdata_i (mem_rdata),
    .irq_i       (irq),
    .reg_addr_i  (reg_addr),
    .reg_wdata_i (reg_wdata),
    .reg_wr_i    (reg_wr),
    .reg_rd_i    (reg_rd),
    .reg_rdata_o (reg_rdata)
  );
  crf_mem_model mem_m (
    .core_clk_i (core_clk),
    .mem_req_i  (mem_req),
    .rdata_o    (mem_rdata)
  );

  // ==========================================================
  // Tasks
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] d;
    reg_read(a, d);
    check($sformatf("register %0h", a), d, v);
  endtask
  // Bounded wait on a register value, since the core gives no done flag
  task automatic wait_reg(input logic [3:0] a, input logic [7:0] v);
    logic [7:0] d;
    reg_read(a, d);
    for (int i = 0; i < 200 && d !== v; i++) begin
      reg_read(a, d);
    end
    check($sformatf("register %0h reached", a), d, v);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end

  // ==========================================================
  // Main sequence
  initial begin
    mem_m.mem[16'hFFFE] = 8'h10;
    mem_m.mem[16'hFFFF] = 8'h00;
    mem_m.mem[16'hFFFC] = 8'h20;
    mem_m.mem[16'hFFFD] = 8'h00;
    mem_m.mem[16'hFFFA] = 8'h30;
    mem_m.mem[16'hFFFB] = 8'h00;
    foreach (prog[i]) mem_m.mem[16'h1000 + i] = prog[i];
    mem_m.mem[16'h2000] = 8'h24;
    mem_m.mem[16'h2001] = 8'hFE;
    mem_m.mem[16'h2002] = 8'h80;
    mem_m.mem[16'h3000] = 8'h24;
    mem_m.mem[16'h3001] = 8'hFE;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_reg(REG_PCL, 8'h14);
    reg_write(REG_CTRL, 8'h00);
    foreach (rows[i]) expect_reg(rows[i].a, rows[i].v);
    // Writes cannot clear the fixed ones nor touch the mask
    reg_write(REG_CCR, 8'h00);
    expect_reg(REG_CCR, 8'h60);
    reg_write(REG_CCR, 8'hF4);
    // Two requests at once; the handler spins with the line still high
    irq <= 4'h3;
    reg_write(REG_CTRL, 8'h01);
    wait_reg(REG_PCH, 8'h20);
    repeat (30) @(posedge core_clk);
    reg_write(REG_CTRL, 8'h00);
    expect_reg(REG_SPL, 8'hFA);
    expect_reg(REG_CCR, 8'hFC);
    expect_reg(REG_STAT, 8'h03);
    check("stack pcl", mem_m.mem[16'h01FF], 8'h12);
    check("stack pch", mem_m.mem[16'h01FE], 8'h10);
    check("stack x", mem_m.mem[16'h01FD], 8'hFE);
    check("stack a", mem_m.mem[16'h01FC], 8'h80);
    check("stack ccr", mem_m.mem[16'h01FB], 8'hF4);
    // Steer the halted core onto the return instruction
    @(posedge core_clk);
    irq <= 4'h0;
    reg_write(REG_PCH, 8'h20);
    reg_write(REG_PCL, 8'h02);
    reg_write(REG_CTRL, 8'h01);
    wait_reg(REG_PCH, 8'h10);
    reg_write(REG_CTRL, 8'h00);
    expect_reg(REG_CCR, 8'hF4);
    expect_reg(REG_SPL, 8'hFF);
    // Signed branch meets N and V both set and must fall through
    foreach (prog2[i]) mem_m.mem[16'h4000 + i] = prog2[i];
    mem_m.mem[16'h0201] = 8'h1A;
    reg_write(REG_PCH, 8'h40);
    reg_write(REG_PCL, 8'h00);
    reg_write(REG_CTRL, 8'h01);
    wait_reg(REG_PCL, 8'h0E);
    reg_write(REG_CTRL, 8'h00);
    expect_reg(REG_A, 8'hE1);
    expect_reg(REG_CCR, 8'h64);
    // Second reset of the halted core with a new vector
    mem_m.mem[16'hFFFE] = 8'h30;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    expect_reg(REG_SPH, 8'h00);
    expect_reg(REG_SPL, 8'hFF);
    expect_reg(REG_CCR, 8'h68);
    expect_reg(REG_CTRL, 8'h01);
    wait_reg(REG_PCH, 8'h30);
    conclude();
  end
endmodule
`default_nettype wire

// >>> tb/crf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module crf_mem_model
  import crf_pkg::*;
(
  // Clock
  input  wire logic         core_clk_i,
  // Request from the core
  input  wire crf_mem_req_s mem_req_i,
  output logic [7:0]        rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] rdata_q = 8'h5A;

  assign rdata_o = rdata_q;

  // ==========================================================
  // Read data stands one cycle; an idle bus toggles so that a
  // core sampling late never sees a stale byte
  always @(posedge core_clk_i) begin
    if (mem_req_i.wr) begin
      mem[mem_req_i.addr] <= mem_req_i.wdata;
    end
    if (mem_req_i.rd) begin
      rdata_q <= mem[mem_req_i.addr];
    end else begin
      rdata_q <= ~rdata_q;
    end
  end
endmodule
`default_nettype wire
